//--- hdl/nvmseq_pkg.sv
package nvmseq_pkg;
   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_CONTROL   = 12'h018c;
   localparam logic [11:0] ADDR_ADDR_LOW  = 12'h0190;
   localparam logic [11:0] ADDR_ADDR_HIGH = 12'h0194;
   localparam logic [11:0] ADDR_DATA_LOW  = 12'h0198;
   localparam logic [11:0] ADDR_DATA_HIGH = 12'h019c;
   localparam logic [11:0] ADDR_IRQ_STAT  = 12'h01a0;
   localparam logic [11:0] ADDR_IRQ_MASK  = 12'h01a4;
   localparam logic [11:0] ADDR_RST_CAUSE = 12'h01a8;

   // ------------------------------------------------------------
   // control, interrupt and reset-cause register fields
   // ------------------------------------------------------------
   localparam int BIT_READ_START  = 0;
   localparam int BIT_WRITE_START = 1;
   localparam int BIT_PERMIT      = 2;
   localparam int BIT_ABORT       = 3;
   localparam int BIT_MEM_SELECT  = 7;
   localparam int BIT_IRQ_DONE    = 0;
   localparam int BIT_IRQ_ABORT   = 1;
   localparam int BIT_CAUSE_EXT   = 0;
   localparam int BIT_CAUSE_WDT   = 1;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // array timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ       = 100;
   localparam int ERASE_US      = 2;
   localparam int PROGRAM_US    = 2;
   localparam int ERASE_CYCLES  = ERASE_US * CLK_MHZ;
   localparam int PROG_CYCLES   = PROGRAM_US * CLK_MHZ;
   localparam int READ_CYCLES   = 2;

   typedef enum logic [2:0] {
      NVMSEQ_IDLE    = 3'b000,
      NVMSEQ_READ    = 3'b001,
      NVMSEQ_ERASE   = 3'b010,
      NVMSEQ_PROGRAM = 3'b011,
      NVMSEQ_FINISH  = 3'b100
   } nvmseq_state_t;

   typedef struct packed {
      logic        req;
      logic        wr;
      logic        prog;
      logic [12:0] addr;
      logic [13:0] wdata;
   } nvmseq_mem_cmd_t;
endpackage

//--- hdl/nvmseq_timer.sv
`timescale 1ns/1ps
module nvmseq_timer #(
   parameter int WIDTH = 16
) (
   input  wire logic             mclk,
   input  wire logic             rstn,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] count,
   output logic                  expired
);
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic             run;
      logic             exp;
   } nvmseq_tmr_t;

   nvmseq_tmr_t st, next_st;

   initial begin
      if (WIDTH < 2) $error("nvmseq_timer: WIDTH too small");
   end

   always_comb begin
      next_st     = st;
      next_st.exp = 1'b0;
      if (load) begin
         next_st.cnt = count;
         next_st.run = 1'b1;
      end else if (st.run) begin
         if (st.cnt <= WIDTH'(1)) begin
            next_st.run = 1'b0;
            next_st.exp = 1'b1;
         end else begin
            next_st.cnt = st.cnt - WIDTH'(1);
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign expired = st.exp;
endmodule

//--- hdl/nvmseq_top.sv
`timescale 1ns/1ps
module nvmseq_top
   import nvmseq_pkg::*;
#(
   parameter int ERASE_COUNT = nvmseq_pkg::ERASE_CYCLES,
   parameter int PROG_COUNT  = nvmseq_pkg::PROG_CYCLES
) (
   input  wire logic                         mclk,
   input  wire logic                         rstn,
   input  wire logic                         por_n,
   input  wire logic                         ext_reset,
   input  wire logic                         wdt_reset,
   input  wire logic [11:0]                  s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   input  wire logic [11:0]                  s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [31:0]                       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   output nvmseq_pkg::nvmseq_mem_cmd_t       mem_cmd,
   input  wire logic [13:0]                  mem_rdata,
   output logic                              core_stall,
   output logic                              irq
);
   import nvmseq_pkg::*;

   localparam int TW = 16;

   initial begin
      if (ERASE_COUNT < 1 || ERASE_COUNT >= (1 << TW))
         $error("nvmseq_top: ERASE_COUNT out of range");
      if (PROG_COUNT < 1 || PROG_COUNT >= (1 << TW))
         $error("nvmseq_top: PROG_COUNT out of range");
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      nvmseq_state_t   fsm;
      logic            select;
      logic            permit;
      logic            wstart;
      logic            rstart;
      logic            abort;
      logic [7:0]      addr_lo;
      logic [4:0]      addr_hi;
      logic [7:0]      data_lo;
      logic [5:0]      data_hi;
      logic [1:0]      irq_stat;
      logic [1:0]      irq_mask;
      logic [1:0]      cause;
      logic [1:0]      rd_wait;
      logic            aw_held;
      logic [11:0]     aw_addr;
      logic            w_held;
      logic [31:0]     w_data;
      logic [3:0]      w_strb;
      logic            awready;
      logic            wready;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            arready;
      logic            rvalid;
      logic [1:0]      rresp;
      logic [31:0]     rdata;
      nvmseq_mem_cmd_t cmd;
      logic            stall;
      logic            irq;
   } nvmseq_top_state_t;

   nvmseq_top_state_t st, next_st;
   logic              tmr_load;
   logic [TW-1:0]     tmr_count;
   logic              tmr_done;

   nvmseq_timer #(
      .WIDTH   (TW)
   ) u_timer (
      .mclk    (mclk),
      .rstn    (rstn),
      .load    (tmr_load),
      .count   (tmr_count),
      .expired (tmr_done)
   );

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb begin
      logic        busy;
      logic        do_wr;
      logic        ok;
      logic [7:0]  wb;
      logic [1:0]  set;
      logic [31:0] rd;
      busy       = 1'b0;
      do_wr      = 1'b0;
      ok         = 1'b0;
      wb         = 8'h00;
      set        = 2'b00;
      rd         = 32'h0000_0000;
      next_st    = st;
      tmr_load   = 1'b0;
      tmr_count  = '0;
      next_st.cmd.req = 1'b0;
      busy = (st.fsm != NVMSEQ_IDLE);

      if (!ext_reset && !wdt_reset) begin
         // write channel capture, either order
         if (s_axi_awvalid && st.awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
            next_st.awready = 1'b0;
         end
         if (s_axi_wvalid && st.wready) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
            next_st.wready = 1'b0;
         end
         if (st.aw_held && st.w_held && !st.bvalid) begin
            do_wr           = st.w_strb[0];
            wb              = st.w_data[7:0];
            ok              = 1'b1;
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            if (st.aw_addr == ADDR_CONTROL) begin
               if (do_wr) begin
                  if (!busy) begin
                     next_st.select = wb[BIT_MEM_SELECT];
                  end
                  next_st.permit = wb[BIT_PERMIT];
                  next_st.abort  = wb[BIT_ABORT];
                  if (wb[BIT_WRITE_START] && st.permit && !busy) begin
                     next_st.wstart = 1'b1;
                  end
                  if (wb[BIT_READ_START] && !busy) begin
                     next_st.rstart = 1'b1;
                  end
               end
            end else if (st.aw_addr == ADDR_ADDR_LOW) begin
               if (do_wr && !busy) next_st.addr_lo = wb;
            end else if (st.aw_addr == ADDR_ADDR_HIGH) begin
               if (do_wr && !busy) next_st.addr_hi = wb[4:0];
            end else if (st.aw_addr == ADDR_DATA_LOW) begin
               if (do_wr && !busy) next_st.data_lo = wb;
            end else if (st.aw_addr == ADDR_DATA_HIGH) begin
               if (do_wr && !busy) next_st.data_hi = wb[5:0];
            end else if (st.aw_addr == ADDR_IRQ_STAT) begin
               if (do_wr) next_st.irq_stat = st.irq_stat & ~wb[1:0];
            end else if (st.aw_addr == ADDR_IRQ_MASK) begin
               if (do_wr) next_st.irq_mask = wb[1:0];
            end else if (st.aw_addr == ADDR_RST_CAUSE) begin
               if (do_wr) next_st.cause = st.cause & ~wb[1:0];
            end else begin
               ok = 1'b0;
            end
            next_st.bresp = ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (st.bvalid && s_axi_bready) begin
            next_st.bvalid  = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready  = 1'b1;
         end

         // read channel
         if (s_axi_arvalid && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid  = 1'b1;
            next_st.rresp   = RESP_OKAY;
            if (s_axi_araddr == ADDR_CONTROL) begin
               rd[BIT_MEM_SELECT]  = st.select;
               rd[BIT_ABORT]       = st.abort;
               rd[BIT_PERMIT]      = st.permit;
               rd[BIT_WRITE_START] = st.wstart;
               rd[BIT_READ_START]  = st.rstart;
            end else if (s_axi_araddr == ADDR_ADDR_LOW) begin
               rd[7:0] = st.addr_lo;
            end else if (s_axi_araddr == ADDR_ADDR_HIGH) begin
               rd[4:0] = st.addr_hi;
            end else if (s_axi_araddr == ADDR_DATA_LOW) begin
               rd[7:0] = st.data_lo;
            end else if (s_axi_araddr == ADDR_DATA_HIGH) begin
               rd[5:0] = st.data_hi;
            end else if (s_axi_araddr == ADDR_IRQ_STAT) begin
               rd[1:0] = st.irq_stat;
            end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
               rd[1:0] = st.irq_mask;
            end else if (s_axi_araddr == ADDR_RST_CAUSE) begin
               rd[1:0] = st.cause;
            end else begin
               next_st.rresp = RESP_SLVERR;
            end
            next_st.rdata = rd;
         end
         if (st.rvalid && s_axi_rready) begin
            next_st.rvalid  = 1'b0;
            next_st.arready = 1'b1;
         end

         // sequencer
         case (st.fsm)
            NVMSEQ_IDLE: begin
               if (st.wstart) begin
                  next_st.cmd.req   = 1'b1;
                  next_st.cmd.wr    = 1'b0;
                  next_st.cmd.prog  = st.select;
                  next_st.cmd.addr  = st.select ?
                                      {st.addr_hi, st.addr_lo} :
                                      {5'h00, st.addr_lo};
                  next_st.stall     = st.select;
                  tmr_load          = 1'b1;
                  tmr_count         = TW'(ERASE_COUNT);
                  next_st.fsm       = NVMSEQ_ERASE;
               end else if (st.rstart) begin
                  next_st.cmd.req   = 1'b1;
                  next_st.cmd.wr    = 1'b0;
                  next_st.cmd.prog  = st.select;
                  next_st.cmd.addr  = st.select ?
                                      {st.addr_hi, st.addr_lo} :
                                      {5'h00, st.addr_lo};
                  next_st.rd_wait   = 2'(READ_CYCLES);
                  next_st.fsm       = NVMSEQ_READ;
               end
            end
            NVMSEQ_READ: begin
               if (st.rd_wait <= 2'd1) begin
                  next_st.data_lo = mem_rdata[7:0];
                  if (st.select) next_st.data_hi = mem_rdata[13:8];
                  next_st.rstart  = 1'b0;
                  next_st.fsm     = NVMSEQ_IDLE;
               end else begin
                  next_st.rd_wait = st.rd_wait - 2'd1;
               end
            end
            NVMSEQ_ERASE: begin
               if (tmr_done) begin
                  next_st.cmd.req   = 1'b1;
                  next_st.cmd.wr    = 1'b1;
                  next_st.cmd.prog  = st.select;
                  next_st.cmd.wdata = st.select ?
                                      {st.data_hi, st.data_lo} :
                                      {6'h00, st.data_lo};
                  tmr_load          = 1'b1;
                  tmr_count         = TW'(PROG_COUNT);
                  next_st.fsm       = NVMSEQ_PROGRAM;
               end
            end
            NVMSEQ_PROGRAM: begin
               if (tmr_done) begin
                  next_st.fsm = NVMSEQ_FINISH;
               end
            end
            NVMSEQ_FINISH: begin
               next_st.wstart = 1'b0;
               next_st.stall  = 1'b0;
               set[BIT_IRQ_DONE] = 1'b1;
               next_st.fsm    = NVMSEQ_IDLE;
            end
            default: begin
               next_st.fsm = NVMSEQ_IDLE;
            end
         endcase
      end else begin
         // external or watchdog reset: address, data and select kept; permit, starts and irq_mask cleared
         if (st.fsm == NVMSEQ_ERASE || st.fsm == NVMSEQ_PROGRAM) begin
            next_st.abort     = 1'b1;
            set[BIT_IRQ_ABORT] = 1'b1;
         end
         next_st.fsm     = NVMSEQ_IDLE;
         next_st.permit  = 1'b0;
         next_st.wstart  = 1'b0;
         next_st.rstart  = 1'b0;
         next_st.stall   = 1'b0;
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.awready = 1'b1;
         next_st.wready  = 1'b1;
         next_st.bvalid  = 1'b0;
         next_st.arready = 1'b1;
         next_st.rvalid  = 1'b0;
         next_st.irq_mask = 2'b00;
         next_st.cause[BIT_CAUSE_EXT] = st.cause[BIT_CAUSE_EXT] | ext_reset;
         next_st.cause[BIT_CAUSE_WDT] = st.cause[BIT_CAUSE_WDT] | wdt_reset;
      end

      // set wins over a same-cycle clear
      next_st.irq_stat = next_st.irq_stat | set;
      next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st         <= '0;
         st.awready <= 1'b1;
         st.wready  <= 1'b1;
         st.arready <= 1'b1;
      end else if (!por_n) begin
         st         <= '0;
         st.awready <= 1'b1;
         st.wready  <= 1'b1;
         st.arready <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign s_axi_awready = st.awready;
   assign s_axi_wready  = st.wready;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_arready = st.arready;
   assign s_axi_rdata   = st.rdata;
   assign s_axi_rresp   = st.rresp;
   assign s_axi_rvalid  = st.rvalid;
   assign mem_cmd       = st.cmd;
   assign core_stall    = st.stall;
   assign irq           = st.irq;
endmodule

//--- dv/nvmseq_array_model.sv
`timescale 1ns/1ps
module nvmseq_array_model
   import nvmseq_pkg::*;
(
   input  wire logic                        mclk,
   input  wire nvmseq_pkg::nvmseq_mem_cmd_t mem_cmd,
   output logic [13:0]                      mem_rdata
);
   logic [13:0] cells [logic [13:0]];
   logic [13:0] key;
   logic [13:0] armed_key;
   logic [13:0] last;
   logic        armed;
   int          n_cmd;
   int          bad;
   int          hold;

   function automatic logic [13:0] peek(input logic [13:0] k);
      return cells.exists(k) ? cells[k] : 14'h3fff;
   endfunction

   // data memory decodes only the low address byte
   assign key = mem_cmd.prog ? {1'b1, mem_cmd.addr}
                             : {6'h00, mem_cmd.addr[7:0]};

   initial begin
      n_cmd = 0;
      bad = 0;
      hold = 0;
      armed = 1'b0;
      last = 14'h0000;
   end

   // --------------------------------------------------------------
   // array access
   // --------------------------------------------------------------
   always @(posedge mclk) begin
      if (hold > 0) hold <= hold - 1;
      if (mem_cmd.req) begin
         n_cmd <= n_cmd + 1;
         if (!mem_cmd.wr) begin
            // a read and an erase look alike: arm for a program
            armed <= 1'b1;
            armed_key <= key;
            last <= peek(key);
            hold <= READ_CYCLES + 1;
         end else begin
            if (!armed || armed_key != key) bad <= bad + 1;
            cells[key] = mem_cmd.prog ? mem_cmd.wdata
                                      : {6'h00, mem_cmd.wdata[7:0]};
            armed <= 1'b0;
         end
      end
   end

   // read data stands only while held, then changes
   assign mem_rdata = (mem_cmd.req && !mem_cmd.wr) ? peek(key)
                    : (hold > 0) ? last : ~last;
endmodule

//--- dv/nvmseq_top_assertions.sv
`timescale 1ns/1ps
module nvmseq_top_assertions
   import nvmseq_pkg::*;
#(
   parameter int ERASE_COUNT = nvmseq_pkg::ERASE_CYCLES,
   parameter int PROG_COUNT  = nvmseq_pkg::PROG_CYCLES
) (
   input  wire logic                        mclk,
   input  wire logic                        rstn,
   input  wire logic                        por_n,
   input  wire logic                        ext_reset,
   input  wire logic                        wdt_reset,
   input  wire nvmseq_pkg::nvmseq_mem_cmd_t mem_cmd,
   input  wire logic                        core_stall
);
   localparam int REL_MAX = PROG_COUNT + 8;
   logic quiet;

   assign quiet = !rstn || !por_n || ext_reset || wdt_reset;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (quiet);

   sequence read_or_erase_s;
      mem_cmd.req && !mem_cmd.wr;
   endsequence
   sequence program_s;
      mem_cmd.req && mem_cmd.wr;
   endsequence
   sequence prog_word_s;
      mem_cmd.req && mem_cmd.wr && mem_cmd.prog;
   endsequence

   erase_first_a: assert property (program_s |->
      $past(mem_cmd.req && !mem_cmd.wr, ERASE_COUNT + 1))
      else $error("program without preceding erase");
   same_target_a: assert property (program_s |->
      $past(mem_cmd.addr, ERASE_COUNT + 1) == mem_cmd.addr &&
      $past(mem_cmd.prog, ERASE_COUNT + 1) == mem_cmd.prog)
      else $error("target changed during write");
   data_runs_a: assert property (read_or_erase_s ##0 !mem_cmd.prog |->
      !core_stall) else $error("core stalled for data access");
   prog_stall_a: assert property (prog_word_s |-> core_stall)
      else $error("program word without stall");
   stall_hold_a: assert property ($rose(core_stall) |->
      core_stall[*8]) else $error("stall dropped early");
   stall_release_a: assert property (prog_word_s |->
      ##[1:REL_MAX] !core_stall) else $error("stall not released");
   req_pulse_a: assert property (mem_cmd.req |=> !mem_cmd.req)
      else $error("array request longer than one cycle");
   reset_idle_a: assert property (disable iff (!rstn || !por_n)
      (ext_reset || wdt_reset) |=> !mem_cmd.req && !core_stall)
      else $error("sequencer active during reset");
endmodule

bind nvmseq_top nvmseq_top_assertions #(
   .ERASE_COUNT(ERASE_COUNT),
   .PROG_COUNT(PROG_COUNT)
) nvmseq_top_assertions_i (
   .mclk(mclk),
   .rstn(rstn),
   .por_n(por_n),
   .ext_reset(ext_reset),
   .wdt_reset(wdt_reset),
   .mem_cmd(mem_cmd),
   .core_stall(core_stall)
);

//--- dv/tb_nvm_write_read_sequencer.sv
`timescale 1ns/1ps
module tb_nvm_write_read_sequencer;
   import nvmseq_pkg::*;
   localparam int EC = 8;
   logic            mclk, rstn, por_n, ext_reset, wdt_reset, irq;
   logic [11:0]     s_axi_awaddr, s_axi_araddr;
   logic [31:0]     s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]      s_axi_wstrb;
   logic [1:0]      s_axi_bresp, s_axi_rresp, rsp;
   logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic            s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic            s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic            s_axi_rready, core_stall, stall_seen;
   nvmseq_mem_cmd_t mem_cmd;
   logic [13:0]     mem_rdata;
   int              n_fail, compares, cyc;

   nvmseq_top #(.ERASE_COUNT(EC), .PROG_COUNT(EC)) nvmseq_top_i (
      .mclk, .rstn, .por_n, .ext_reset, .wdt_reset, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .mem_cmd, .mem_rdata, .core_stall, .irq);
   nvmseq_array_model nvmseq_array_model_i (.mclk, .mem_cmd, .mem_rdata);

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // ---------------------------------------------------------------
   // watchdog on the run and stall monitor
   // ---------------------------------------------------------------
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (core_stall === 1'b1) stall_seen <= 1'b1;
      if (cyc == 20000) begin
         n_fail++;
         complete_run;
      end
   end

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // ---------------------------------------------------------------
   // bus tasks
   // ---------------------------------------------------------------
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge mclk);
         if (s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge mclk);
      while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [11:0] a);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge mclk);
      while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk);
      while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] m,
                        input logic [31:0] e);
      axi_rd(a);
      check(rd & m, e);
   endtask

   task automatic wait_idle;
      do axi_rd(ADDR_CONTROL);
      while (rd[1:0] !== 2'b00);
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      rdchk(ADDR_CONTROL, 32'h0000_0007, 32'h0000_0000);
      axi_rd(12'h1b0);
      check(rsp, RESP_SLVERR);
      wr(12'h1b0, 32'h0000_0000);
      check(rsp, RESP_SLVERR);
      check(irq, 1'b0);
      wr(ADDR_CONTROL, 32'h0000_0000);
      rdchk(ADDR_CONTROL, 32'h0000_0008, 32'h0000_0000);
      $display("reset test done");
   endtask

   task automatic t_no_permit;
      int n0;
      n0 = nvmseq_array_model_i.n_cmd;
      wr(ADDR_ADDR_LOW, 32'h0000_0011);
      wr(ADDR_CONTROL, 32'h0000_0002);
      repeat (3 * EC) @(posedge mclk);
      check(nvmseq_array_model_i.n_cmd, n0);
      rdchk(ADDR_CONTROL, 32'h0000_0002, 32'h0000_0000);
      $display("permit test done");
   endtask

   task automatic t_data_write;
      wr(ADDR_IRQ_STAT, 32'h0000_0003);
      wr(ADDR_IRQ_MASK, 32'h0000_0000);
      wr(ADDR_ADDR_LOW, 32'h0000_005a);
      wr(ADDR_DATA_LOW, 32'h0000_00c3);
      wr(ADDR_CONTROL, 32'h0000_0004);
      stall_seen = 1'b0;
      wr(ADDR_CONTROL, 32'h0000_0006);
      wr(ADDR_CONTROL, 32'h0000_0084);
      rdchk(ADDR_CONTROL, 32'h0000_0086, 32'h0000_0006);
      wait_idle;
      check(stall_seen, 1'b0);
      check(nvmseq_array_model_i.peek(14'h005a), 14'h00c3);
      check(nvmseq_array_model_i.bad, 0);
      rdchk(ADDR_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
      rdchk(ADDR_CONTROL, 32'h0000_0008, 32'h0000_0000);
      check(irq, 1'b0);
      wr(ADDR_IRQ_MASK, 32'h0000_0001);
      repeat (2) @(posedge mclk);
      check(irq, 1'b1);
      wr(ADDR_IRQ_STAT, 32'h0000_0001);
      repeat (2) @(posedge mclk);
      check(irq, 1'b0);
      $display("data write test done");
   endtask

   task automatic t_prog_write;
      wr(ADDR_ADDR_LOW, 32'h0000_0034);
      wr(ADDR_ADDR_HIGH, 32'h0000_0012);
      wr(ADDR_DATA_LOW, 32'h0000_00a5);
      wr(ADDR_DATA_HIGH, 32'h0000_002b);
      wr(ADDR_CONTROL, 32'h0000_0084);
      stall_seen = 1'b0;
      wr(ADDR_CONTROL, 32'h0000_0086);
      wait_idle;
      check(stall_seen, 1'b1);
      check(core_stall, 1'b0);
      check(nvmseq_array_model_i.peek(14'h3234), 14'h2ba5);
      check(nvmseq_array_model_i.bad, 0);
      rdchk(ADDR_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
      $display("program write test done");
   endtask

   task automatic t_read;
      wr(ADDR_DATA_LOW, 32'h0000_0000);
      wr(ADDR_DATA_HIGH, 32'h0000_0000);
      wr(ADDR_CONTROL, 32'h0000_0081);
      repeat (2) @(posedge mclk);
      rdchk(ADDR_CONTROL, 32'h0000_0001, 32'h0000_0000);
      rdchk(ADDR_DATA_LOW, 32'h0000_00ff, 32'h0000_00a5);
      rdchk(ADDR_DATA_HIGH, 32'h0000_003f, 32'h0000_002b);
      wr(ADDR_ADDR_LOW, 32'h0000_005a);
      wr(ADDR_CONTROL, 32'h0000_0001);
      repeat (2) @(posedge mclk);
      rdchk(ADDR_DATA_LOW, 32'h0000_00ff, 32'h0000_00c3);
      $display("read test done");
   endtask

   task automatic t_abort;
      for (int k = 0; k < 2; k++) begin
         wr(ADDR_CONTROL, 32'h0000_0084);
         wr(ADDR_CONTROL, 32'h0000_0086);
         @(posedge mclk);
         if (k == 0) ext_reset <= 1'b1;
         else wdt_reset <= 1'b1;
         repeat (2) @(posedge mclk);
         ext_reset <= 1'b0;
         wdt_reset <= 1'b0;
         @(posedge mclk);
         check(core_stall, 1'b0);
         rdchk(ADDR_CONTROL, 32'h0000_008e, 32'h0000_0088);
         rdchk(ADDR_ADDR_LOW, 32'h0000_00ff, 32'h0000_005a);
         rdchk(ADDR_ADDR_HIGH, 32'h0000_001f, 32'h0000_0012);
         rdchk(ADDR_DATA_LOW, 32'h0000_00ff, 32'h0000_00c3);
         rdchk(ADDR_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
         rdchk(ADDR_RST_CAUSE, 32'h0000_0003, 32'(k + 1));
         wr(ADDR_RST_CAUSE, 32'h0000_0003);
         wr(ADDR_IRQ_STAT, 32'h0000_0003);
         wr(ADDR_CONTROL, 32'h0000_0080);
         rdchk(ADDR_CONTROL, 32'h0000_0008, 32'h0000_0000);
      end
      $display("abort test done");
   endtask

   initial begin
      rstn = 1'b0;
      por_n = 1'b1;
      ext_reset = 1'b0;
      wdt_reset = 1'b0;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'h1;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      stall_seen = 1'b0;
      n_fail = 0;
      compares = 0;
      cyc = 0;
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      t_reset;
      t_no_permit;
      t_data_write;
      t_prog_write;
      t_read;
      t_abort;
      por_n <= 1'b0;
      @(posedge mclk);
      por_n <= 1'b1;
      rdchk(ADDR_ADDR_LOW, 32'h0000_00ff, 32'h0000_0000);
      complete_run;
   end
endmodule
